// [mdld_consts.vh]
// Constants for the multiply/divide/logic instruction decoder
`ifndef MDLD_CONSTS_VH
`define MDLD_CONSTS_VH
// Opcode patterns (upper bits compared, low bits are w/d/s; the adjust and extend codes are whole bytes)
`define MDLD_OP_GRP3 7'h7B
`define MDLD_OP_IMULI_HI 6'h1A
`define MDLD_OP_ADJP 8'hD4
`define MDLD_OP_ADJQ 8'hD5
`define MDLD_OP_ADJ2 8'h0A
`define MDLD_OP_EXTB 8'h98
`define MDLD_OP_EXTW 8'h99
`define MDLD_OP_SH1 7'h68
`define MDLD_OP_SHCL 7'h69
`define MDLD_OP_SHIMM 7'h60
`define MDLD_OP_AND_RM 6'h08
`define MDLD_OP_AND_ACC 7'h12
`define MDLD_OP_OR_RM 6'h02
`define MDLD_OP_OR_ACC 7'h06
`define MDLD_OP_IMM_GRP 7'h40
`define MDLD_OP_TEST_RM 7'h42
`define MDLD_OP_TEST_ACC 7'h54
// ModRM reg field codes, then the mod code for a register operand
`define MDLD_REG_TEST 3'h0
`define MDLD_REG_OR 3'h1
`define MDLD_REG_NOT 3'h2
`define MDLD_REG_NGT 3'h3
`define MDLD_REG_AND 3'h4
`define MDLD_REG_UMUL 3'h4
`define MDLD_REG_SMUL 3'h5
`define MDLD_REG_DIV 3'h6
`define MDLD_REG_SDIV 3'h7
`define MDLD_MOD_REG 2'h3
// Operation codes driven to the datapath
`define MDLD_OPC_NONE 5'h00
`define MDLD_OPC_SMUL 5'h01
`define MDLD_OPC_IMULI 5'h02
`define MDLD_OPC_DIV 5'h03
`define MDLD_OPC_SDIV 5'h04
`define MDLD_OPC_ADJP 5'h05
`define MDLD_OPC_ADJQ 5'h06
`define MDLD_OPC_EXTB 5'h07
`define MDLD_OPC_EXTW 5'h08
`define MDLD_OPC_AND 5'h09
`define MDLD_OPC_OR 5'h0A
`define MDLD_OPC_TEST 5'h0B
`define MDLD_OPC_SHIFT 5'h0C
`define MDLD_OPC_UMUL 5'h0D
`define MDLD_OPC_NGT 5'h0E
`define MDLD_OPC_NOT 5'h0F
// Clock counts: {word mem, byte mem, word reg, byte reg} minimum / maximum
`define MDLD_T_SMUL_MIN 32'h281F2219
`define MDLD_T_SMUL_MAX 32'h2B22251C
`define MDLD_T_UMUL_MIN 32'h2920231A
`define MDLD_T_UMUL_MAX 32'h2B22251C
`define MDLD_T_DIV 32'h2C23261D
`define MDLD_T_SDIV_MIN 32'h3B32352C
`define MDLD_T_SDIV_MAX 32'h433A3D34
`define MDLD_T_IMULI_REG_MIN 8'h16
`define MDLD_T_IMULI_REG_MAX 8'h19
`define MDLD_T_IMULI_MEM_MIN 8'h1D
`define MDLD_T_IMULI_MEM_MAX 8'h20
`define MDLD_T_ADJP 8'h13
`define MDLD_T_ADJQ 8'h0F
`define MDLD_T_EXTB 8'h02
`define MDLD_T_EXTW 8'h04
`define MDLD_T_RM_REG 8'h03
`define MDLD_T_RM_MEM 8'h0A
`define MDLD_T_IMM_REG 8'h04
`define MDLD_T_IMM_MEM 8'h10
`define MDLD_T_ACC_B 8'h03
`define MDLD_T_ACC_W 8'h04
`define MDLD_T_TEST_IMM_MEM 8'h0A
`define MDLD_T_SH1_REG 8'h02
`define MDLD_T_SH1_MEM 8'h0F
`define MDLD_T_SHN_REG 8'h05
`define MDLD_T_SHN_MEM 8'h11
`endif

// [mdld_timing_rom.v]
// Small registered table of clock-count limits for the grp3 multiply/divide forms
`timescale 1ns/1ps
`include "mdld_consts.vh"
module mdld_timing_rom (
    input wire ref_clk_i,
    input wire rst_n_i,
    input wire [2:0] sel_i,
    input wire [1:0] form_i,
    output reg [7:0] min_o,
    output reg [7:0] max_o
);
    // Table packed per kind; index form = {mem, word}
    function [7:0] pick;
        input [31:0] tab;
        input [1:0] f;
        begin
            pick = tab[f*8 +: 8];
        end
    endfunction

    reg [31:0] tmin;
    reg [31:0] tmax;
    always @* begin
        case (sel_i)
            3'h1: begin
                tmin = `MDLD_T_SMUL_MIN;
                tmax = `MDLD_T_SMUL_MAX;
            end
            3'h2: begin
                tmin = `MDLD_T_UMUL_MIN;
                tmax = `MDLD_T_UMUL_MAX;
            end
            3'h3: begin
                tmin = `MDLD_T_DIV;
                tmax = `MDLD_T_DIV;
            end
            3'h4: begin
                tmin = `MDLD_T_SDIV_MIN;
                tmax = `MDLD_T_SDIV_MAX;
            end
            default: begin
                tmin = 32'h00000000;
                tmax = 32'h00000000;
            end
        endcase
    end

    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            min_o <= 8'h00;
            max_o <= 8'h00;
        end else begin
            min_o <= pick(tmin, form_i);
            max_o <= pick(tmax, form_i);
        end
    end
endmodule // mdld_timing_rom

// [mdld_decoder.v]
// Instruction decoder for multiply, divide, adjust, extend, shift and logic forms
`timescale 1ns/1ps
`include "mdld_consts.vh"

// Functional notes
// RULE1: grp3 reg 101 is signed multiply, timed
// RULE2: 011010s1 immediate multiply; second byte if s=0
// RULE3: grp3 reg 110 is unsigned divide, timed
// RULE4: grp3 reg 111 is signed divide, timed
// RULE5: D4 0A adjust after product, 19 clocks
// RULE6: D5 0A adjust before quotient, 15 clocks
// RULE7: 98 byte to word extend, 2 clocks
// RULE8: 99 word to double extend, 4 clocks
// RULE9: AND three forms with their clock counts
// RULE10: OR three forms with their clock counts
// RULE11: 1000010w test rm with register, 3/10
// RULE12: grp3 reg 000 test immediate, 4/10
// RULE13: 1010100w test accumulator immediate, 3/4
// RULE14: Shift group: by one, count_low_register, immediate
// RULE15: Shift time 2/15, or 5+n/17+n
// RULE16: grp3 reg 100 unsigned multiply, timed
// RULE17: grp3 reg 011 negate, 3/10
// RULE18: grp3 reg 010 invert, 3/10
module mdld_decoder #(
    parameter CNT_W = 8
) (
    input wire ref_clk_i,
    input wire rst_n_i,
    input wire byte_valid_i,
    input wire [7:0] byte_i,
    input wire [7:0] count_low_register_i,
    output reg decode_done_o,
    output reg [4:0] op_code_o,
    output reg word_o,
    output reg mem_o,
    output reg dir_o,
    output reg [2:0] shift_kind_field_o,
    output reg [1:0] imm_bytes_o,
    output reg flags_only_o,
    output reg [CNT_W-1:0] clk_min_o,
    output reg [CNT_W-1:0] clk_max_o,
    output reg [7:0] shift_count_o,
    output reg unknown_o
);
    ////////////////////////////////////////////////////////////////////
    localparam [5:0] S_OP = 6'h01;
    localparam [5:0] S_MODRM = 6'h02;
    localparam [5:0] S_ADJ = 6'h04;
    localparam [5:0] S_IMM = 6'h08;
    localparam [5:0] S_ROM = 6'h10;
    localparam [5:0] S_IMM2 = 6'h20;

    reg [5:0] state;
    reg [7:0] op;
    reg [7:0] modrm;
    reg [1:0] imm_left;
    reg [7:0] first_imm;

    wire [2:0] rf = byte_i[5:3];
    wire is_reg = (byte_i[7:6] == `MDLD_MOD_REG);
    wire w = op[0];

    // Opcodes that need a ModRM byte
    function needs_modrm;
        input [7:0] o;
        begin
            needs_modrm = (o[7:1] == `MDLD_OP_GRP3) ||
                (o[7:2] == `MDLD_OP_IMULI_HI && o[0]) ||
                (o[7:1] == `MDLD_OP_SH1) || (o[7:1] == `MDLD_OP_SHCL) ||
                (o[7:1] == `MDLD_OP_SHIMM) || (o[7:2] == `MDLD_OP_AND_RM) ||
                (o[7:2] == `MDLD_OP_OR_RM) || (o[7:1] == `MDLD_OP_IMM_GRP) ||
                (o[7:1] == `MDLD_OP_TEST_RM);
        end
    endfunction

    function [CNT_W-1:0] rm_time;
        input r;
        input [7:0] treg;
        input [7:0] tmem;
        begin
            rm_time = r ? treg : tmem;
        end
    endfunction

    // Grp3 timing lookup through the registered table
    reg [2:0] rom_sel;
    reg [1:0] rom_form;
    wire [7:0] rom_min;
    wire [7:0] rom_max;
    reg [4:0] rom_op;

    mdld_timing_rom u_rom (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .sel_i(rom_sel),
        .form_i(rom_form),
        .min_o(rom_min),
        .max_o(rom_max)
    );

    always @* begin
        rom_sel = 3'h0;
        rom_form = {~is_reg, w};
        case (rf)
            `MDLD_REG_SMUL: rom_sel = 3'h1; // RULE1
            `MDLD_REG_UMUL: rom_sel = 3'h2; // RULE16
            `MDLD_REG_DIV: rom_sel = 3'h3; // RULE3
            `MDLD_REG_SDIV: rom_sel = 3'h4; // RULE4
            default: rom_sel = 3'h0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    task finish;
        input [4:0] opc;
        input [7:0] tmin;
        input [7:0] tmax;
        begin
            decode_done_o <= 1'b1;
            op_code_o <= opc;
            clk_min_o <= tmin;
            clk_max_o <= tmax;
            state <= S_OP;
        end
    endtask

    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= S_OP;
            op <= 8'h00;
            modrm <= 8'h00;
            imm_left <= 2'h0;
            first_imm <= 8'h00;
            rom_op <= `MDLD_OPC_NONE;
            decode_done_o <= 1'b0;
            op_code_o <= `MDLD_OPC_NONE;
            word_o <= 1'b0;
            mem_o <= 1'b0;
            dir_o <= 1'b0;
            shift_kind_field_o <= 3'h0;
            imm_bytes_o <= 2'h0;
            flags_only_o <= 1'b0;
            clk_min_o <= {CNT_W{1'b0}};
            clk_max_o <= {CNT_W{1'b0}};
            shift_count_o <= 8'h00;
            unknown_o <= 1'b0;
        end else begin
            decode_done_o <= 1'b0;
            unknown_o <= 1'b0;
            case (state)
                S_OP: if (byte_valid_i) begin
                    op <= byte_i;
                    word_o <= byte_i[0];
                    dir_o <= byte_i[1];
                    mem_o <= 1'b0;
                    flags_only_o <= 1'b0;
                    imm_bytes_o <= 2'h0;
                    shift_count_o <= 8'h00;
                    if (needs_modrm(byte_i))
                        state <= S_MODRM;
                    else if (byte_i == `MDLD_OP_ADJP || byte_i == `MDLD_OP_ADJQ)
                        state <= S_ADJ; // RULE5 RULE6
                    else if (byte_i == `MDLD_OP_EXTB)
                        finish(`MDLD_OPC_EXTB, `MDLD_T_EXTB, `MDLD_T_EXTB); // RULE7
                    else if (byte_i == `MDLD_OP_EXTW)
                        finish(`MDLD_OPC_EXTW, `MDLD_T_EXTW, `MDLD_T_EXTW); // RULE8
                    else if (byte_i[7:1] == `MDLD_OP_AND_ACC ||
                             byte_i[7:1] == `MDLD_OP_OR_ACC ||
                             byte_i[7:1] == `MDLD_OP_TEST_ACC) begin
                        // Accumulator immediate forms; word takes a second byte
                        imm_bytes_o <= byte_i[0] ? 2'h2 : 2'h1; // RULE9 RULE10 RULE13
                        imm_left <= byte_i[0] ? 2'h2 : 2'h1;
                        flags_only_o <= (byte_i[7:1] == `MDLD_OP_TEST_ACC); // RULE13
                        state <= S_IMM;
                    end else begin
                        unknown_o <= 1'b1;
                    end
                end
                S_ADJ: if (byte_valid_i) begin
                    // Only the 0A second byte is recognised
                    if (byte_i != `MDLD_OP_ADJ2) begin
                        unknown_o <= 1'b1;
                        state <= S_OP;
                    end else if (op == `MDLD_OP_ADJP)
                        finish(`MDLD_OPC_ADJP, `MDLD_T_ADJP, `MDLD_T_ADJP); // RULE5
                    else
                        finish(`MDLD_OPC_ADJQ, `MDLD_T_ADJQ, `MDLD_T_ADJQ); // RULE6
                end
                S_MODRM: if (byte_valid_i) begin
                    modrm <= byte_i;
                    mem_o <= ~is_reg;
                    shift_kind_field_o <= rf;
                    if (op[7:1] == `MDLD_OP_GRP3) begin
                        case (rf)
                            `MDLD_REG_TEST: begin
                                imm_bytes_o <= w ? 2'h2 : 2'h1; // RULE12
                                imm_left <= w ? 2'h2 : 2'h1;
                                flags_only_o <= 1'b1;
                                state <= S_IMM;
                            end
                            `MDLD_REG_NGT: finish(`MDLD_OPC_NGT,
                                rm_time(is_reg, `MDLD_T_RM_REG, `MDLD_T_RM_MEM),
                                rm_time(is_reg, `MDLD_T_RM_REG, `MDLD_T_RM_MEM)); // RULE17
                            `MDLD_REG_NOT: finish(`MDLD_OPC_NOT,
                                rm_time(is_reg, `MDLD_T_RM_REG, `MDLD_T_RM_MEM),
                                rm_time(is_reg, `MDLD_T_RM_REG, `MDLD_T_RM_MEM)); // RULE18
                            `MDLD_REG_UMUL, `MDLD_REG_SMUL, `MDLD_REG_DIV,
                            `MDLD_REG_SDIV: begin
                                // Table answers one cycle later
                                rom_op <= (rf == `MDLD_REG_SMUL) ? `MDLD_OPC_SMUL :
                                    (rf == `MDLD_REG_UMUL) ? `MDLD_OPC_UMUL :
                                    (rf == `MDLD_REG_DIV) ? `MDLD_OPC_DIV :
                                    `MDLD_OPC_SDIV; // RULE1 RULE3 RULE4 RULE16
                                state <= S_ROM;
                            end
                            default: begin
                                // Reg 001 has no operation; a zero-time answer would mislead
                                unknown_o <= 1'b1;
                                state <= S_OP;
                            end
                        endcase
                    end else if (op[7:2] == `MDLD_OP_IMULI_HI) begin
                        imm_bytes_o <= op[1] ? 2'h1 : 2'h2; // RULE2
                        imm_left <= op[1] ? 2'h1 : 2'h2;
                        state <= S_IMM;
                    end else if (op[7:1] == `MDLD_OP_SH1) begin
                        shift_count_o <= 8'h01;
                        finish(`MDLD_OPC_SHIFT,
                            rm_time(is_reg, `MDLD_T_SH1_REG, `MDLD_T_SH1_MEM),
                            rm_time(is_reg, `MDLD_T_SH1_REG, `MDLD_T_SH1_MEM)); // RULE14 RULE15
                    end else if (op[7:1] == `MDLD_OP_SHCL) begin
                        shift_count_o <= count_low_register_i;
                        finish(`MDLD_OPC_SHIFT,
                            rm_time(is_reg, `MDLD_T_SHN_REG, `MDLD_T_SHN_MEM) +
                                count_low_register_i,
                            rm_time(is_reg, `MDLD_T_SHN_REG, `MDLD_T_SHN_MEM) +
                                count_low_register_i); // RULE14 RULE15
                    end else if (op[7:1] == `MDLD_OP_SHIMM) begin
                        imm_bytes_o <= 2'h1; // RULE14
                        imm_left <= 2'h1;
                        state <= S_IMM;
                    end else if (op[7:1] == `MDLD_OP_IMM_GRP) begin
                        // Only AND and OR reg codes belong to this block
                        if (rf == `MDLD_REG_AND || rf == `MDLD_REG_OR) begin
                            imm_bytes_o <= w ? 2'h2 : 2'h1; // RULE9 RULE10
                            imm_left <= w ? 2'h2 : 2'h1;
                            state <= S_IMM;
                        end else begin
                            unknown_o <= 1'b1;
                            state <= S_OP;
                        end
                    end else if (op[7:1] == `MDLD_OP_TEST_RM) begin
                        flags_only_o <= 1'b1;
                        finish(`MDLD_OPC_TEST,
                            rm_time(is_reg, `MDLD_T_RM_REG, `MDLD_T_RM_MEM),
                            rm_time(is_reg, `MDLD_T_RM_REG, `MDLD_T_RM_MEM)); // RULE11
                    end else begin
                        finish((op[7:2] == `MDLD_OP_AND_RM) ? `MDLD_OPC_AND : `MDLD_OPC_OR,
                            rm_time(is_reg, `MDLD_T_RM_REG, `MDLD_T_RM_MEM),
                            rm_time(is_reg, `MDLD_T_RM_REG, `MDLD_T_RM_MEM)); // RULE9 RULE10
                    end
                end
                S_ROM:
                    finish(rom_op, rom_min, rom_max); // RULE1 RULE3 RULE4 RULE16
                S_IMM: if (byte_valid_i) begin
                    if (imm_left == 2'h2) begin
                        first_imm <= byte_i;
                        imm_left <= 2'h1;
                    end else begin
                        state <= S_IMM2;
                        first_imm <= byte_i;
                    end
                end
                S_IMM2: begin
                    // All immediates taken; pick times from the form
                    if (op[7:1] == `MDLD_OP_SHIMM) begin
                        shift_count_o <= first_imm;
                        finish(`MDLD_OPC_SHIFT,
                            rm_time(~mem_o, `MDLD_T_SHN_REG, `MDLD_T_SHN_MEM) + first_imm,
                            rm_time(~mem_o, `MDLD_T_SHN_REG, `MDLD_T_SHN_MEM) +
                                first_imm); // RULE15
                    end else if (op[7:2] == `MDLD_OP_IMULI_HI)
                        finish(`MDLD_OPC_IMULI,
                            rm_time(~mem_o, `MDLD_T_IMULI_REG_MIN, `MDLD_T_IMULI_MEM_MIN),
                            rm_time(~mem_o, `MDLD_T_IMULI_REG_MAX,
                                `MDLD_T_IMULI_MEM_MAX)); // RULE2
                    else if (op[7:1] == `MDLD_OP_GRP3)
                        finish(`MDLD_OPC_TEST,
                            rm_time(~mem_o, `MDLD_T_IMM_REG, `MDLD_T_TEST_IMM_MEM),
                            rm_time(~mem_o, `MDLD_T_IMM_REG, `MDLD_T_TEST_IMM_MEM)); // RULE12
                    else if (op[7:1] == `MDLD_OP_IMM_GRP)
                        finish((modrm[5:3] == `MDLD_REG_AND) ? `MDLD_OPC_AND : `MDLD_OPC_OR,
                            rm_time(~mem_o, `MDLD_T_IMM_REG, `MDLD_T_IMM_MEM),
                            rm_time(~mem_o, `MDLD_T_IMM_REG, `MDLD_T_IMM_MEM)); // RULE9 RULE10
                    else
                        finish((op[7:1] == `MDLD_OP_AND_ACC) ? `MDLD_OPC_AND :
                            (op[7:1] == `MDLD_OP_OR_ACC) ? `MDLD_OPC_OR : `MDLD_OPC_TEST,
                            w ? `MDLD_T_ACC_W : `MDLD_T_ACC_B,
                            w ? `MDLD_T_ACC_W : `MDLD_T_ACC_B); // RULE9 RULE10 RULE13
                end
                default: state <= S_OP;
            endcase
        end
    end
endmodule // mdld_decoder

// [mdld_queue_model.sv]
// Prefetch queue model that offers instruction bytes with a gap after each one
`timescale 1ns/1ps
module mdld_queue_model (
    input wire ref_clk_i,
    input wire rst_n_i,
    input wire go_i,
    input wire [31:0] bytes_i,
    input wire [2:0] len_i,
    output logic byte_valid_o,
    output logic [7:0] byte_o
);
logic [31:0] q;
logic [2:0] left;
// One idle cycle after every byte covers the hold-off after ModRM and immediates
always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        left <= 3'h0;
        q <= 32'h0;
        byte_valid_o <= 1'b0;
        byte_o <= 8'hFF;
    end else if (go_i && left == 3'h0) begin
        left <= len_i;
        q <= bytes_i;
        byte_valid_o <= 1'b0;
        byte_o <= ~byte_o;
    end else if (left != 3'h0 && !byte_valid_o) begin
        byte_valid_o <= 1'b1;
        byte_o <= q[7:0];
        q <= q >> 8;
        left <= left - 3'h1;
    end else begin
        // Idle bus shows the inverse, so a stale byte never passes for a fresh one
        byte_valid_o <= 1'b0;
        byte_o <= ~byte_o;
    end
end
endmodule // mdld_queue_model

// [mdld_decoder_chk.sv]
// Assertion checker for the decoder's outputs
`timescale 1ns/1ps
module mdld_decoder_chk #(
    parameter CNT_W = 8
) (
    input wire ref_clk_i,
    input wire rst_n_i,
    input wire byte_valid_i,
    input wire [7:0] byte_i,
    input wire [7:0] count_low_register_i,
    input wire decode_done_o,
    input wire [4:0] op_code_o,
    input wire word_o,
    input wire mem_o,
    input wire dir_o,
    input wire [2:0] shift_kind_field_o,
    input wire [1:0] imm_bytes_o,
    input wire flags_only_o,
    input wire [CNT_W-1:0] clk_min_o,
    input wire [CNT_W-1:0] clk_max_o,
    input wire [7:0] shift_count_o,
    input wire unknown_o
);
// Minimum counts indexed by {mem, word}, byte register form in the low byte
localparam [31:0] T_SMUL = 32'h281F2219;
localparam [31:0] T_DIV = 32'h2C23261D;
localparam [31:0] T_SDIV = 32'h3B32352C;
localparam [31:0] T_UMUL = 32'h2920231A;
default clocking cb @(posedge ref_clk_i); endclocking
default disable iff (!rst_n_i);
function automatic [7:0] pick(input [31:0] t, input [1:0] s);
    pick = t[{s, 3'h0} +: 8];
endfunction
wire dn = decode_done_o;
wire [1:0] fm = {mem_o, word_o};
////////////////////////////////////////////////////////////////////////////////
a_extend_byte_time: assert property (dn && op_code_o == 5'h07 |->
    clk_min_o == 8'h02 && clk_max_o == 8'h02 && $past(byte_i) == 8'h98 && $past(byte_valid_i))
    else $error("byte extend decode wrong");
a_extend_word_time: assert property (dn && op_code_o == 5'h08 |->
    clk_min_o == 8'h04 && clk_max_o == 8'h04 && $past(byte_i) == 8'h99)
    else $error("word extend decode wrong");
a_adjust_prod_time: assert property (dn && op_code_o == 5'h05 |->
    clk_min_o == 8'h13 && clk_max_o == 8'h13 && $past(byte_i) == 8'h0A)
    else $error("adjust after product decode wrong");
a_adjust_quot_time: assert property (dn && op_code_o == 5'h06 |->
    clk_min_o == 8'h0F && clk_max_o == 8'h0F) else $error("adjust before quotient wrong");
a_signed_prod_span: assert property (dn && op_code_o == 5'h01 |->
    clk_min_o == pick(T_SMUL, fm) && clk_max_o == clk_min_o + 8'h03)
    else $error("signed multiply counts wrong");
a_divide_fixed: assert property (dn && op_code_o == 5'h03 |->
    clk_min_o == pick(T_DIV, fm) && clk_max_o == clk_min_o) else $error("divide counts wrong");
a_signed_div_span: assert property (dn && op_code_o == 5'h04 |->
    clk_min_o == pick(T_SDIV, fm) && clk_max_o == clk_min_o + 8'h08)
    else $error("signed divide counts wrong");
a_unsigned_prod_span: assert property (dn && op_code_o == 5'h0D |->
    clk_min_o == pick(T_UMUL, fm) && clk_max_o == clk_min_o + 8'h02)
    else $error("unsigned multiply counts wrong");
a_imm_prod_form: assert property (dn && op_code_o == 5'h02 |->
    imm_bytes_o == (dir_o ? 2'h1 : 2'h2) && clk_min_o == (mem_o ? 8'h1D : 8'h16)
    && clk_max_o == clk_min_o + 8'h03) else $error("immediate multiply decode wrong");
a_test_flags_only: assert property (dn |-> flags_only_o == (op_code_o == 5'h0B))
    else $error("flags-only marking wrong");
a_negate_invert: assert property (dn && op_code_o inside {5'h0E, 5'h0F} |->
    clk_min_o == (mem_o ? 8'h0A : 8'h03) && clk_max_o == clk_min_o)
    else $error("negate or invert counts wrong");
c_shift: cover property (dn && op_code_o == 5'h0C);
c_unknown: cover property (unknown_o);
c_signed_divide_mem: cover property (dn && op_code_o == 5'h04 && mem_o);
endmodule // mdld_decoder_chk
bind mdld_decoder mdld_decoder_chk #(.CNT_W(CNT_W)) u_mdld_decoder_chk (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .byte_valid_i(byte_valid_i), .byte_i(byte_i),
    .count_low_register_i(count_low_register_i), .decode_done_o(decode_done_o),
    .op_code_o(op_code_o), .word_o(word_o), .mem_o(mem_o), .dir_o(dir_o),
    .shift_kind_field_o(shift_kind_field_o), .imm_bytes_o(imm_bytes_o),
    .flags_only_o(flags_only_o), .clk_min_o(clk_min_o), .clk_max_o(clk_max_o),
    .shift_count_o(shift_count_o), .unknown_o(unknown_o));

// [tb_top.sv]
// Self-checking testbench for the instruction decoder
`timescale 1ns/1ps
module tb_top;
logic ref_clk_i = 1'b0;
logic rst_n_i = 1'b1;
logic go = 1'b0;
logic [31:0] pkt = 32'h0;
logic [2:0] pkt_len = 3'h0;
logic [7:0] cnt_low = 8'h00;
logic [7:0] e_cnt = 8'h01;
logic bv, done, word, mem, dir, flags, unk;
logic [7:0] bd, cmin, cmax, scnt;
logic [4:0] op;
logic [2:0] kind;
logic [1:0] imm;
int num_errors = 0;
int checks_done = 0;
int cycles = 0;
// Multiply/divide minimum counts: byte reg, word reg, byte mem, word mem
logic [7:0] g3_min [16] = '{8'h19, 8'h22, 8'h1F, 8'h28, 8'h1D, 8'h26, 8'h23, 8'h2C,
    8'h2C, 8'h35, 8'h32, 8'h3B, 8'h1A, 8'h23, 8'h20, 8'h29};
logic [7:0] g3_span [4] = '{8'h03, 8'h00, 8'h08, 8'h02};
logic [2:0] g3_reg [4] = '{3'h5, 3'h6, 3'h7, 3'h4};
logic [4:0] g3_op [4] = '{5'h01, 5'h03, 5'h04, 5'h0D};
always #5 ref_clk_i = ~ref_clk_i;
mdld_queue_model u_mdld_queue_model (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .go_i(go),
    .bytes_i(pkt), .len_i(pkt_len), .byte_valid_o(bv), .byte_o(bd));
mdld_decoder u_mdld_decoder (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .byte_valid_i(bv),
    .byte_i(bd), .count_low_register_i(cnt_low), .decode_done_o(done), .op_code_o(op),
    .word_o(word), .mem_o(mem), .dir_o(dir), .shift_kind_field_o(kind), .imm_bytes_o(imm),
    .flags_only_o(flags), .clk_min_o(cmin), .clk_max_o(cmax), .shift_count_o(scnt),
    .unknown_o(unk));
////////////////////////////////////////////////////////////////////////////////
task automatic wrap_up;
    if (num_errors == 0 && checks_done > 0)
        $display("[ PASS ]");
    else
        $display("[ FAIL ]");
    $finish;
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
        num_errors++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
// Op code zero means the sequence must be refused with an unknown pulse
task automatic send(input logic [31:0] b, input logic [2:0] n, input logic [4:0] e_op,
        input logic [7:0] mn, input logic [7:0] mx, input logic [1:0] e_imm);
    int i;
    pkt = b;
    pkt_len = n;
    go = 1'b1;
    @(posedge ref_clk_i);
    #1 go = 1'b0;
    for (i = 0; i < 60 && done !== 1'b1 && unk !== 1'b1; i++) @(negedge ref_clk_i);
    chk({done, unk}, (e_op == 5'h00) ? 2'h1 : 2'h2);
    if (e_op != 5'h00) begin
        chk(op, e_op);
        chk(cmin, mn);
        chk(cmax, mx);
        chk(imm, e_imm);
        chk(flags, e_op == 5'h0B);
        chk(word, b[0]);
        if (e_op == 5'h0C) begin
            chk(scnt, e_cnt);
            chk(kind, b[13:11]);
        end
    end
    @(posedge ref_clk_i);
    #1;
endtask
////////////////////////////////////////////////////////////////////////////////
task automatic t_extend_adjust;
    send(32'h98, 3'h1, 5'h07, 8'h02, 8'h02, 2'h0);
    send(32'h99, 3'h1, 5'h08, 8'h04, 8'h04, 2'h0);
    send(32'h0AD4, 3'h2, 5'h05, 8'h13, 8'h13, 2'h0);
    send(32'h0AD5, 3'h2, 5'h06, 8'h0F, 8'h0F, 2'h0);
    send(32'h0BD4, 3'h2, 5'h00, 8'h00, 8'h00, 2'h0);
    send(32'h90, 3'h1, 5'h00, 8'h00, 8'h00, 2'h0);
    send(32'h68, 3'h1, 5'h00, 8'h00, 8'h00, 2'h0);
endtask
task automatic t_grp3;
    int k;
    int f;
    logic [7:0] m;
    for (k = 0; k < 4; k++) begin
        for (f = 0; f < 4; f++) begin
            m = {f[1] ? 2'h0 : 2'h3, g3_reg[k], 3'h0};
            send({16'h0, m, 7'h7B, f[0]}, 3'h2, g3_op[k], g3_min[k * 4 + f],
                g3_min[k * 4 + f] + g3_span[k], 2'h0);
        end
    end
    send(32'h5AC06B, 3'h3, 5'h02, 8'h16, 8'h19, 2'h1);
    send(32'hA55A0069, 3'h4, 5'h02, 8'h1D, 8'h20, 2'h2);
    send(32'hD8F6, 3'h2, 5'h0E, 8'h03, 8'h03, 2'h0);
    send(32'h18F7, 3'h2, 5'h0E, 8'h0A, 8'h0A, 2'h0);
    send(32'hD0F6, 3'h2, 5'h0F, 8'h03, 8'h03, 2'h0);
    send(32'h10F7, 3'h2, 5'h0F, 8'h0A, 8'h0A, 2'h0);
    send(32'hC8F6, 3'h2, 5'h00, 8'h00, 8'h00, 2'h0);
endtask
task automatic t_logic;
    int k;
    logic [7:0] rb;
    logic [7:0] ab;
    logic [7:0] m;
    logic [4:0] e;
    for (k = 0; k < 2; k++) begin
        rb = k ? 8'h08 : 8'h20;
        ab = k ? 8'h0C : 8'h24;
        m = k ? 8'h08 : 8'h20;
        e = k ? 5'h0A : 5'h09;
        send({16'h0, 8'hC0, rb}, 3'h2, e, 8'h03, 8'h03, 2'h0);
        send({16'h0, 8'h00, rb | 8'h03}, 3'h2, e, 8'h0A, 8'h0A, 2'h0);
        send({8'h0, 8'h5A, 8'hC1 | m, 8'h80}, 3'h3, e, 8'h04, 8'h04, 2'h1);
        send({8'hA5, 8'h5A, m, 8'h81}, 3'h4, e, 8'h10, 8'h10, 2'h2);
        send({16'h0, 8'h5A, ab}, 3'h2, e, 8'h03, 8'h03, 2'h1);
        send({8'h0, 8'hA5, 8'h5A, ab | 8'h01}, 3'h3, e, 8'h04, 8'h04, 2'h2);
    end
    send(32'hC084, 3'h2, 5'h0B, 8'h03, 8'h03, 2'h0);
    send(32'h0085, 3'h2, 5'h0B, 8'h0A, 8'h0A, 2'h0);
    send(32'h5AC0F6, 3'h3, 5'h0B, 8'h04, 8'h04, 2'h1);
    send(32'hA55A00F7, 3'h4, 5'h0B, 8'h0A, 8'h0A, 2'h2);
    send(32'h5AA8, 3'h2, 5'h0B, 8'h03, 8'h03, 2'h1);
    send(32'hA55AA9, 3'h3, 5'h0B, 8'h04, 8'h04, 2'h2);
endtask
task automatic t_shift;
    int k;
    e_cnt = 8'h01;
    for (k = 0; k < 8; k++) begin
        if (k != 6)
            send({16'h0, 2'h3, k[2:0], 3'h0, 8'hD0}, 3'h2, 5'h0C, 8'h02, 8'h02, 2'h0);
    end
    send(32'h00D1, 3'h2, 5'h0C, 8'h0F, 8'h0F, 2'h0);
    cnt_low = 8'h05;
    e_cnt = 8'h05;
    send(32'hE8D2, 3'h2, 5'h0C, 8'h0A, 8'h0A, 2'h0);
    cnt_low = 8'h03;
    e_cnt = 8'h03;
    send(32'h00D3, 3'h2, 5'h0C, 8'h14, 8'h14, 2'h0);
    e_cnt = 8'h07;
    send(32'h07C8C0, 3'h3, 5'h0C, 8'h0C, 8'h0C, 2'h1);
    e_cnt = 8'h00;
    send(32'h0000C1, 3'h3, 5'h0C, 8'h11, 8'h11, 2'h1);
endtask
////////////////////////////////////////////////////////////////////////////////
always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
        num_errors++;
        wrap_up();
    end
end
initial begin
    rst_n_i = 1'b0;
    repeat (5) @(posedge ref_clk_i);
    #1 rst_n_i = 1'b1;
    t_extend_adjust();
    t_grp3();
    t_logic();
    t_shift();
    wrap_up();
end
endmodule // tb_top
